// *** lars_regs.vh ***
// Contract
// - Five shots per request, each with four timers and a config word.
// - Trip uses protection timing; start uses starting delay.
// - Higher-priority request takes over shot settings.
// - Critical lock cleared only by manual reset.
// - Breaker commanded only through object control.
// - Delayed close holds until partner acknowledges.
// - Blocked open waits for acknowledgement likewise.
// - Failure acknowledgement forces lock-out until reset.
// - Lock-out left by external reset or closing.
// - Five requests arbitrated, request one first.
// - Critical request halts sequence and locks out.
// - Request during reclaim starts next enabled shot, unless it comes within action time of a non-arc shot.
// - No shot left: final trip, then lock-out.
`ifndef LARS_REGS_VH
`define LARS_REGS_VH

// *****************************************************************
// Register word addresses.
// *****************************************************************
`define LARS_ADDR_CTRL 8'h00
`define LARS_ADDR_STAT 8'h01
`define LARS_ADDR_IRQ_STAT 8'h02
`define LARS_ADDR_IRQ_CLR 8'h03
`define LARS_ADDR_IRQ_EN 8'h04
`define LARS_SET_BASE_BIT 7
`define LARS_SET_COUNT 125

// *****************************************************************
// Field positions and reset values.
// *****************************************************************
`define LARS_CTRL_EN_BIT 0
`define LARS_CTRL_SRC_LSB 8
`define LARS_CTRL_RST 32'h0000_0001
`define LARS_CFG_EN_BIT 0
`define LARS_CFG_ARC_BIT 1
`define LARS_F_START 3'h0
`define LARS_F_DEAD 3'h1
`define LARS_F_ACTION 3'h2
`define LARS_F_RECLAIM 3'h3
`define LARS_F_CFG 3'h4
`define LARS_IRQ_SHOT 0
`define LARS_IRQ_LOCK 1
`define LARS_IRQ_FINAL 2
`define LARS_IRQ_DONE 3
`define LARS_IRQ_CRIT 4

// *****************************************************************
// Timing.
// *****************************************************************
`define LARS_CLK_PERIOD_NS 4
`define LARS_TICK_NS 5000000
`define LARS_TICK_CYC (`LARS_TICK_NS / `LARS_CLK_PERIOD_NS)
`define LARS_TMR_W 19
`define LARS_TMR_MAX 19'h57e40

`endif

// *** lars_tick.v ***
`include "lars_regs.vh"

// *****************************************************************
// Divider that yields the one-cycle timer tick.
// *****************************************************************
module lars_tick #(
  parameter integer TICK_CYC = `LARS_TICK_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Tick out
  output reg tick
);
  reg [20:0] cnt_ff;

  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 21'h0;
      tick <= 1'b0;
    end else if (cnt_ff == TICK_CYC[20:0] - 21'h1) begin
      cnt_ff <= 21'h0;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 21'h1;
      tick <= 1'b0;
    end
  end
endmodule // lars_tick

// *** lars_top.v ***
// The register addresses and the plain strobed port were left to the implementer.
`include "lars_regs.vh"

module lars_top #(
  parameter integer TICK_CYC = `LARS_TICK_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Register port
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  // Protection requests
  input wire [4:0] REQ,
  input wire CRIT_REQ,
  input wire EXT_RST,
  input wire MAN_RST_REMOTE,
  input wire MAN_RST_LOCAL,
  // Object control partner
  input wire BRK_OPEN,
  input wire BRK_CLOSED,
  input wire OBJ_WAIT,
  input wire OBJ_ACK_OK,
  input wire OBJ_ACK_FAIL,
  output reg OPEN_CMD,
  output reg CLOSE_CMD,
  // Indications
  output reg RUNNING,
  output reg [4:0] REQUESTED,
  output reg [4:0] SHOT_RUN,
  output reg LOCKOUT,
  output reg FINAL_TRIP,
  output reg IRQ
);
  // *****************************************************************
  // States.
  // *****************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_STARTD = 3'h1;
  localparam [2:0] ST_ARC = 3'h2;
  localparam [2:0] ST_OPEN = 3'h3;
  localparam [2:0] ST_DEAD = 3'h4;
  localparam [2:0] ST_CLOSE = 3'h5;
  localparam [2:0] ST_RECLAIM = 3'h6;
  localparam [2:0] ST_LOCK = 3'h7;
  localparam [2:0] NONE = 3'h5;

  reg [`LARS_TMR_W-1:0] set_ff [0:`LARS_SET_COUNT-1];
  reg [31:0] ctrl_ff;
  reg [4:0] irq_st_ff;
  reg [4:0] irq_en_ff;
  reg [2:0] st_ff;
  reg [2:0] req_ff;
  reg [2:0] shot_ff;
  reg [`LARS_TMR_W-1:0] tmr_ff;
  reg [4:0] req_d_ff;
  reg brk_cl_d_ff;
  reg crit_lock_ff;
  reg [2:0] nxt_st;
  reg [2:0] nxt_req;
  reg [2:0] nxt_shot;
  reg nxt_crit_lock;
  reg [4:0] ev;
  reg [4:0] en_cur;
  reg [4:0] en_win;
  reg [31:0] rd_mux;
  wire tick;
  wire [4:0] req_rise;
  wire [2:0] win;
  wire [2:0] hp;
  wire src_trip;
  wire arc_mode;
  integer i;
  integer j;

  // *****************************************************************
  // Decoding helpers.
  // *****************************************************************
  function [6:0] sidx;
    input [2:0] r;
    input [2:0] s;
    input [2:0] f;
    begin
      sidx = r * 7'h19 + s * 7'h05 + {4'h0, f};
    end
  endfunction

  // Lowest set bit at or above index lo, NONE when there is none.
  function [2:0] first_from;
    input [4:0] v;
    input [2:0] lo;
    integer k;
    begin
      first_from = NONE;
      for (k = 4; k >= 0; k = k - 1) begin
        if (v[k] && k >= lo) begin
          first_from = k[2:0];
        end
      end
    end
  endfunction

  function [`LARS_TMR_W-1:0] setting;
    input [2:0] r;
    input [2:0] s;
    input [2:0] f;
    begin
      setting = set_ff[sidx(r, s, f)];
    end
  endfunction

  lars_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick)
  );

  assign req_rise = REQ & ~req_d_ff;
  assign win = first_from(req_rise, 3'h0);
  // The highest-priority level request, NONE when no request is set.
  assign hp = first_from(REQ, 3'h0);
  assign src_trip = ctrl_ff[`LARS_CTRL_SRC_LSB + req_ff];
  assign arc_mode = set_ff[sidx(req_ff, shot_ff, `LARS_F_CFG)]
    [`LARS_CFG_ARC_BIT];

  always @* begin
    for (i = 0; i < 5; i = i + 1) begin
      en_cur[i] = set_ff[sidx(req_ff, i[2:0], `LARS_F_CFG)]
        [`LARS_CFG_EN_BIT];
      en_win[i] = (win < NONE) &&
        set_ff[sidx(win, i[2:0], `LARS_F_CFG)][`LARS_CFG_EN_BIT];
    end
  end

  // *****************************************************************
  // Sequencer.
  // *****************************************************************
  always @* begin
    nxt_st = st_ff;
    nxt_req = req_ff;
    nxt_shot = shot_ff;
    nxt_crit_lock = crit_lock_ff;
    ev = 5'h0;
    if (st_ff != ST_IDLE && st_ff != ST_LOCK && hp < req_ff) begin
      nxt_req = hp;
    end
    case (st_ff)
      ST_IDLE: begin
        if (ctrl_ff[`LARS_CTRL_EN_BIT] && win < NONE &&
            first_from(en_win, 3'h0) < NONE) begin
          nxt_req = win;
          nxt_shot = first_from(en_win, 3'h0);
          ev[`LARS_IRQ_SHOT] = 1'b1;
          if (ctrl_ff[`LARS_CTRL_SRC_LSB + win]) begin
            nxt_st = ST_OPEN;
          end else begin
            nxt_st = ST_STARTD;
          end
        end
      end
      ST_STARTD: begin
        if (tmr_ff >= setting(req_ff, shot_ff, `LARS_F_START)) begin
          nxt_st = arc_mode ? ST_ARC : ST_OPEN;
        end
      end
      ST_ARC: begin
        if (tmr_ff >= setting(req_ff, shot_ff, `LARS_F_ACTION)) begin
          nxt_st = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (OBJ_ACK_FAIL) begin
          nxt_st = ST_LOCK;
        end else if (OBJ_ACK_OK || (BRK_OPEN && !OBJ_WAIT)) begin
          nxt_st = ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (tmr_ff >= setting(req_ff, shot_ff, `LARS_F_DEAD)) begin
          nxt_st = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (OBJ_ACK_FAIL) begin
          nxt_st = ST_LOCK;
        end else if (OBJ_ACK_OK || (BRK_CLOSED && !OBJ_WAIT)) begin
          nxt_st = ST_RECLAIM;
        end
      end
      ST_RECLAIM: begin
        if (req_rise != 5'h0) begin
          if (!arc_mode && tmr_ff <
              setting(req_ff, shot_ff, `LARS_F_ACTION)) begin
            // Fault back inside the discrimination window.
            nxt_st = ST_LOCK;
            ev[`LARS_IRQ_FINAL] = 1'b1;
          end else if (first_from(en_cur, shot_ff + 3'h1) < NONE) begin
            nxt_shot = first_from(en_cur, shot_ff + 3'h1);
            ev[`LARS_IRQ_SHOT] = 1'b1;
            nxt_st = src_trip ? ST_OPEN : ST_STARTD;
          end else begin
            nxt_st = ST_LOCK;
            ev[`LARS_IRQ_FINAL] = 1'b1;
          end
        end else if (tmr_ff >=
                     setting(req_ff, shot_ff, `LARS_F_RECLAIM)) begin
          nxt_st = ST_IDLE;
          ev[`LARS_IRQ_DONE] = 1'b1;
        end
      end
      ST_LOCK: begin
        if (crit_lock_ff) begin
          if (MAN_RST_REMOTE || MAN_RST_LOCAL) begin
            nxt_st = ST_IDLE;
            nxt_crit_lock = 1'b0;
          end
        end else if (EXT_RST || (BRK_CLOSED && !brk_cl_d_ff)) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    if (CRIT_REQ) begin
      nxt_st = ST_LOCK;
      nxt_crit_lock = 1'b1;
      ev[`LARS_IRQ_CRIT] = 1'b1;
    end
    if (nxt_st == ST_LOCK && st_ff != ST_LOCK) begin
      ev[`LARS_IRQ_LOCK] = 1'b1;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      st_ff <= ST_IDLE;
      req_ff <= 3'h0;
      shot_ff <= 3'h0;
      tmr_ff <= {`LARS_TMR_W{1'b0}};
      req_d_ff <= 5'h0;
      brk_cl_d_ff <= 1'b0;
      crit_lock_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      shot_ff <= nxt_shot;
      crit_lock_ff <= nxt_crit_lock;
      req_d_ff <= REQ;
      brk_cl_d_ff <= BRK_CLOSED;
      if (nxt_st != st_ff || nxt_shot != shot_ff) begin
        tmr_ff <= {`LARS_TMR_W{1'b0}};
      end else if (tick && tmr_ff != `LARS_TMR_MAX) begin
        tmr_ff <= tmr_ff + 1'b1;
      end
    end
  end

  // *****************************************************************
  // Outputs, all registered.
  // *****************************************************************
  always @(posedge CLK) begin
    if (!RST_N) begin
      OPEN_CMD <= 1'b0;
      CLOSE_CMD <= 1'b0;
      RUNNING <= 1'b0;
      REQUESTED <= 5'h0;
      SHOT_RUN <= 5'h0;
      LOCKOUT <= 1'b0;
      FINAL_TRIP <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      // A trip-driven request leaves the opening to the protection.
      OPEN_CMD <= (nxt_st == ST_OPEN) &&
        !ctrl_ff[`LARS_CTRL_SRC_LSB + nxt_req];
      CLOSE_CMD <= (nxt_st == ST_CLOSE);
      RUNNING <= (nxt_st != ST_IDLE) && (nxt_st != ST_LOCK);
      REQUESTED <= 5'h0;
      SHOT_RUN <= 5'h0;
      if (nxt_st != ST_IDLE && nxt_st != ST_LOCK) begin
        REQUESTED[nxt_req] <= 1'b1;
        SHOT_RUN[nxt_shot] <= 1'b1;
      end
      LOCKOUT <= (nxt_st == ST_LOCK);
      FINAL_TRIP <= ev[`LARS_IRQ_FINAL];
      IRQ <= |((irq_st_ff | ev) & irq_en_ff);
    end
  end

  // *****************************************************************
  // Register port.
  // *****************************************************************
  always @* begin
    rd_mux = 32'h0;
    if (ADDR[`LARS_SET_BASE_BIT]) begin
      if (ADDR[6:0] < `LARS_SET_COUNT) begin
        rd_mux = {13'h0, set_ff[ADDR[6:0]]};
      end
    end else begin
      case (ADDR)
        `LARS_ADDR_CTRL: rd_mux = ctrl_ff;
        `LARS_ADDR_STAT: rd_mux = {20'h0, crit_lock_ff, shot_ff,
          1'b0, req_ff, 1'b0, st_ff};
        `LARS_ADDR_IRQ_STAT: rd_mux = {27'h0, irq_st_ff};
        `LARS_ADDR_IRQ_EN: rd_mux = {27'h0, irq_en_ff};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_ff <= `LARS_CTRL_RST;
      irq_st_ff <= 5'h0;
      irq_en_ff <= 5'h0;
      RDATA <= 32'h0;
      for (j = 0; j < `LARS_SET_COUNT; j = j + 1) begin
        set_ff[j] <= {`LARS_TMR_W{1'b0}};
      end
    end else begin
      RDATA <= RD ? rd_mux : 32'h0;
      if (WR && ADDR[`LARS_SET_BASE_BIT] &&
          ADDR[6:0] < `LARS_SET_COUNT) begin
        if (WDATA[`LARS_TMR_W-1:0] > `LARS_TMR_MAX) begin
          set_ff[ADDR[6:0]] <= `LARS_TMR_MAX;
        end else begin
          set_ff[ADDR[6:0]] <= WDATA[`LARS_TMR_W-1:0];
        end
      end
      if (WR && ADDR == `LARS_ADDR_CTRL) begin
        ctrl_ff <= {19'h0, WDATA[12:8], 7'h0, WDATA[0]};
      end
      if (WR && ADDR == `LARS_ADDR_IRQ_EN) begin
        irq_en_ff <= WDATA[4:0];
      end
      // A new event wins over a clear in the same cycle.
      if (WR && ADDR == `LARS_ADDR_IRQ_CLR) begin
        irq_st_ff <= (irq_st_ff & ~WDATA[4:0]) | ev;
      end else begin
        irq_st_ff <= irq_st_ff | ev;
      end
    end
  end
endmodule // lars_top

// *** lars_chk.sv ***
module lars_chk (
  // Clock, reset and request side
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CRIT_REQ,
  input wire logic EXT_RST,
  input wire logic MAN_RST_REMOTE,
  input wire logic MAN_RST_LOCAL,
  // Object control and indications
  input wire logic OBJ_WAIT,
  input wire logic OBJ_ACK_OK,
  input wire logic OBJ_ACK_FAIL,
  input wire logic OPEN_CMD,
  input wire logic CLOSE_CMD,
  input wire logic RUNNING,
  input wire logic [4:0] REQUESTED,
  input wire logic [4:0] SHOT_RUN,
  input wire logic LOCKOUT,
  input wire logic FINAL_TRIP
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Lock cause tracking
  // ********************
  // Remembers that the present lock-out came from the critical request.
  logic crit_lk_ff;
  logic nxt_crit_lk;
  assign nxt_crit_lk = CRIT_REQ | (crit_lk_ff & LOCKOUT);
  always @(posedge CLK) begin
    if (!RST_N) begin
      crit_lk_ff <= 1'b0;
    end else begin
      crit_lk_ff <= nxt_crit_lk;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_one_cmd: assert property (!(OPEN_CMD && CLOSE_CMD))
    else $error("open and close commanded together");
  a_onehot_ind: assert property ($onehot0(SHOT_RUN) &&
    $onehot0(REQUESTED)) else $error("indication not one-hot");
  a_crit_lock: assert property (CRIT_REQ |=> LOCKOUT && !RUNNING
    && !OPEN_CMD && !CLOSE_CMD) else $error("critical did not lock");
  a_crit_hold: assert property (LOCKOUT && crit_lk_ff &&
    !MAN_RST_REMOTE && !MAN_RST_LOCAL |=> LOCKOUT)
    else $error("critical lock left without manual reset");
  a_close_wait: assert property (CLOSE_CMD && OBJ_WAIT &&
    !OBJ_ACK_OK && !OBJ_ACK_FAIL && !CRIT_REQ |=> CLOSE_CMD)
    else $error("close dropped during wait");
  a_open_wait: assert property (OPEN_CMD && OBJ_WAIT &&
    !OBJ_ACK_OK && !OBJ_ACK_FAIL && !CRIT_REQ |=> OPEN_CMD)
    else $error("open dropped during wait");
  a_fail_lock: assert property ((OPEN_CMD || CLOSE_CMD) &&
    OBJ_ACK_FAIL |=> LOCKOUT && !OPEN_CMD && !CLOSE_CMD)
    else $error("failure did not lock");
  a_final_drop: assert property (FINAL_TRIP |-> LOCKOUT &&
    !RUNNING && SHOT_RUN == 5'h00 && REQUESTED == 5'h00 ##1 !FINAL_TRIP)
    else $error("final trip indications wrong");
  a_ext_unlock: assert property (LOCKOUT && !crit_lk_ff &&
    EXT_RST && !CRIT_REQ |=> !LOCKOUT) else $error("lock not left");
endmodule // lars_chk

// *** lars_obj_model.sv ***
module lars_obj_model (
  // Clock, reset and commands
  input wire logic clk,
  input wire logic rst_n,
  input wire logic open_cmd,
  input wire logic close_cmd,
  // Scenario controls
  input wire logic trip,
  input wire logic shut,
  input wire logic fail,
  input wire logic [3:0] slow,
  // Breaker status and acknowledges
  output logic brk_open,
  output logic brk_closed,
  output logic obj_wait,
  output logic ack_ok,
  output logic ack_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Object control
  // ********************
  logic [3:0] cnt_ff;
  always @(posedge clk) begin
    if (!rst_n) begin
      brk_open <= 1'b0;
      brk_closed <= 1'b1;
      obj_wait <= 1'b0;
      ack_ok <= 1'b0;
      ack_fail <= 1'b0;
      cnt_ff <= 4'h0;
    end else begin
      ack_ok <= 1'b0;
      ack_fail <= 1'b0;
      if (trip || shut) begin
        brk_open <= trip;
        brk_closed <= shut;
      end else if ((open_cmd && !brk_open) ||
                   (close_cmd && !brk_closed)) begin
        obj_wait <= 1'b1;
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff >= slow) begin
          obj_wait <= 1'b0;
          cnt_ff <= 4'h0;
          ack_fail <= fail;
          ack_ok <= !fail;
          if (!fail) begin
            brk_open <= open_cmd;
            brk_closed <= close_cmd;
          end
        end
      end else begin
        obj_wait <= 1'b0;
        cnt_ff <= 4'h0;
      end
    end
  end
endmodule // lars_obj_model

// *** lars_bench.sv ***
`include "lars_regs.vh"

module lars_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FT = 6, LK = 5, RU = 4, CC = 3, OC = 2, BC = 1, S2 = 7;
  logic CLK, RST_N, WR, RD, CRIT_REQ, EXT_RST, MAN_RST_REMOTE;
  logic MAN_RST_LOCAL, OBJ_WAIT, OBJ_ACK_OK, OBJ_ACK_FAIL, BRK_OPEN;
  logic BRK_CLOSED, OPEN_CMD, CLOSE_CMD, RUNNING, LOCKOUT, FINAL_TRIP, IRQ;
  logic trip, shut, fail;
  logic [3:0] slow;
  logic [7:0] ADDR, mon;
  logic [31:0] WDATA, RDATA;
  logic [4:0] REQ, REQUESTED, SHOT_RUN;
  logic [39:0] rows [6];
  int num_errors = 0, check_count = 0, waited;
  assign mon = {SHOT_RUN[1], FINAL_TRIP, LOCKOUT, RUNNING, CLOSE_CMD,
                OPEN_CMD, BRK_CLOSED, IRQ};
  lars_top #(.TICK_CYC(4)) dut_u (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .REQ(REQ),
    .CRIT_REQ(CRIT_REQ), .EXT_RST(EXT_RST), .MAN_RST_REMOTE(MAN_RST_REMOTE),
    .MAN_RST_LOCAL(MAN_RST_LOCAL), .BRK_OPEN(BRK_OPEN),
    .BRK_CLOSED(BRK_CLOSED), .OBJ_WAIT(OBJ_WAIT), .OBJ_ACK_OK(OBJ_ACK_OK),
    .OBJ_ACK_FAIL(OBJ_ACK_FAIL), .OPEN_CMD(OPEN_CMD), .CLOSE_CMD(CLOSE_CMD),
    .RUNNING(RUNNING), .REQUESTED(REQUESTED), .SHOT_RUN(SHOT_RUN),
    .LOCKOUT(LOCKOUT), .FINAL_TRIP(FINAL_TRIP), .IRQ(IRQ));
  lars_obj_model obj_u (.clk(CLK), .rst_n(RST_N), .open_cmd(OPEN_CMD),
    .close_cmd(CLOSE_CMD), .trip(trip), .shut(shut), .fail(fail),
    .slow(slow), .brk_open(BRK_OPEN), .brk_closed(BRK_CLOSED),
    .obj_wait(OBJ_WAIT), .ack_ok(OBJ_ACK_OK), .ack_fail(OBJ_ACK_FAIL));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // ********************
  // Helpers
  // ********************
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wait_on(input int b, input logic v);
    waited = 0;
    while (mon[b] !== v) begin
      @(posedge CLK);
      #1;
      waited++;
      if (waited > 400) begin
        num_errors++;
        tally_and_finish();
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, RDATA);
  endtask
  // Shot with dead time 1 tick, reclaim 20 ticks, enabled and arcing.
  task automatic shot(input int r, input int s, input int st, input int ac);
    int b;
    b = 128 + r * 25 + s * 5;
    wr(8'(b), 32'(st));
    wr(8'(b + 1), 32'h1);
    wr(8'(b + 2), 32'(ac));
    wr(8'(b + 3), 32'h14);
    wr(8'(b + 4), 32'h3);
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    {RST_N, WR, RD, CRIT_REQ, EXT_RST, MAN_RST_REMOTE, MAN_RST_LOCAL} = '0;
    {trip, shut, fail, ADDR, WDATA, REQ} = '0;
    slow = 4'h3;
    rows = '{40'h0000000001, 40'h0100000000, 40'h0200000000,
             40'h0300000000, 40'h0400000000, 40'h0500000000};
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    #1;
    chk("outs", 32'h0,
        {OPEN_CMD, CLOSE_CMD, RUNNING, LOCKOUT, IRQ});
    foreach (rows[i]) rd(rows[i][39:32], rows[i][31:0]);
    wr(`LARS_ADDR_CTRL, 32'h201);
    shot(1, 0, 0, 0);
    shot(1, 1, 0, 0);
    @(posedge CLK);
    REQ <= 5'h02;
    wait_on(RU, 1'b1);
    chk("requested", 32'h02, REQUESTED);
    chk("open cmd", 32'h0, OPEN_CMD);
    for (int k = 0; k < 2; k++) begin
      @(posedge CLK);
      trip <= 1'b1;
      REQ <= 5'h00;
      @(posedge CLK);
      trip <= 1'b0;
      wait_on(CC, 1'b1);
      wait_on(BC, 1'b1);
      wait_on(CC, 1'b0);
      @(posedge CLK);
      REQ <= 5'h02;
      wait_on(k ? FT : S2, 1'b1);
    end
    chk("lock", 32'h1, LOCKOUT);
    chk("irq", 32'h0, IRQ);
    rd(`LARS_ADDR_IRQ_STAT, 32'h7);
    wr(`LARS_ADDR_IRQ_EN, 32'h1f);
    wait_on(0, 1'b1);
    wr(`LARS_ADDR_IRQ_CLR, 32'h1f);
    wait_on(0, 1'b0);
    @(posedge CLK);
    trip <= 1'b1;
    @(posedge CLK);
    trip <= 1'b0;
    shut <= 1'b1;
    @(posedge CLK);
    shut <= 1'b0;
    wait_on(LK, 1'b0);
    wr(`LARS_ADDR_CTRL, 32'h1);
    shot(0, 0, 2, 1);
    slow <= 4'hf;
    @(posedge CLK);
    REQ <= 5'h03;
    wait_on(RU, 1'b1);
    chk("requested", 32'h01, REQUESTED);
    // Two start ticks and one action tick, tick phase unknown.
    wait_on(OC, 1'b1);
    chk("start delay", 32'h1, 32'(waited >= 10 && waited <= 13));
    for (int k = 1; k < 3; k++) begin
      @(posedge CLK);
      CRIT_REQ <= 1'b1;
      @(posedge CLK);
      CRIT_REQ <= 1'b0;
      EXT_RST <= 1'b1;
      wait_on(LK, 1'b1);
      chk("outs", 32'h0, {OPEN_CMD, CLOSE_CMD, RUNNING});
      repeat (3) @(posedge CLK);
      EXT_RST <= 1'b0;
      {MAN_RST_REMOTE, MAN_RST_LOCAL} <= 2'(k);
      #1;
      chk("lock", 32'h1, LOCKOUT);
      wait_on(LK, 1'b0);
      @(posedge CLK);
      {MAN_RST_REMOTE, MAN_RST_LOCAL} <= 2'b00;
    end
    // Second request starts with a long delay, the first takes over.
    slow <= 4'h3;
    REQ <= 5'h00;
    wr(`LARS_ADDR_IRQ_CLR, 32'h1f);
    shot(1, 0, 8, 1);
    @(posedge CLK);
    REQ <= 5'h02;
    wait_on(RU, 1'b1);
    chk("requested", 32'h02, REQUESTED);
    @(posedge CLK);
    REQ <= 5'h03;
    @(posedge CLK);
    #1;
    chk("takeover", 32'h01, REQUESTED);
    wait_on(OC, 1'b1);
    chk("takeover delay", 32'h1, 32'(waited <= 12));
    wait_on(RU, 1'b0);
    chk("lock", 32'h0, LOCKOUT);
    rd(`LARS_ADDR_IRQ_STAT, 32'h9);
    @(posedge CLK);
    fail <= 1'b1;
    REQ <= 5'h00;
    @(posedge CLK);
    REQ <= 5'h01;
    wait_on(OC, 1'b1);
    wait_on(LK, 1'b1);
    chk("outs", 32'h0, {OPEN_CMD, RUNNING});
    @(posedge CLK);
    EXT_RST <= 1'b1;
    fail <= 1'b0;
    wait_on(LK, 1'b0);
    tally_and_finish();
  end
endmodule // lars_bench

bind lars_top lars_chk chk_u (.CLK(CLK), .RST_N(RST_N),
  .CRIT_REQ(CRIT_REQ), .EXT_RST(EXT_RST), .MAN_RST_REMOTE(MAN_RST_REMOTE),
  .MAN_RST_LOCAL(MAN_RST_LOCAL), .OBJ_WAIT(OBJ_WAIT),
  .OBJ_ACK_OK(OBJ_ACK_OK), .OBJ_ACK_FAIL(OBJ_ACK_FAIL),
  .OPEN_CMD(OPEN_CMD), .CLOSE_CMD(CLOSE_CMD), .RUNNING(RUNNING),
  .REQUESTED(REQUESTED), .SHOT_RUN(SHOT_RUN), .LOCKOUT(LOCKOUT),
  .FINAL_TRIP(FINAL_TRIP));
